// *** dv/hetc_checker.sv ***
// Assertions on the ports of hetc_top: APB timing, coefficient writes, reset and sample latency.
// Assumes one clock and the synchronous active-low reset of hetc_top.
`timescale 1ns/1ns
`default_nettype none
module hetc_checker #(
    parameter ADDR_W = 8,
    parameter COEF_W = 8
) (
    // Clock and reset.
    input wire logic              clk_sys_i,
    input wire logic              reset_n_i,
    // APB.
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0]       pwdata_i,
    input wire logic [3:0]        pstrb_i,
    input wire logic [31:0]       prdata_o,
    input wire logic              pready_o,
    input wire logic              pslverr_o,
    // Samples and coefficients.
    input wire logic              sample_valid_i,
    input wire logic              rx_clean_valid_o,
    input wire logic [COEF_W-1:0] tap_one_coeff_o,
    input wire logic [COEF_W-1:0] tap_two_coeff_o,
    input wire logic [COEF_W-1:0] tap_three_coeff_o,
    input wire logic [COEF_W-1:0] tap_four_coeff_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    wire acc = psel_i & penable_i & pready_o;
    wire wr  = acc & pwrite_i & pstrb_i[0];

    property p_setup_ready; psel_i && !penable_i |=> pready_o; endproperty
    a_setup_ready: assert property (p_setup_ready)
        else $error("pready missing after setup");
    property p_ready_pulse; pready_o |=> !pready_o; endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready longer than one cycle");
    property p_tap_one_wr; wr && paddr_i == 8'hb4 |=> tap_one_coeff_o == $past(pwdata_i[7:0]); endproperty
    a_tap_one_wr: assert property (p_tap_one_wr)
        else $error("tap one coefficient not written");
    property p_tap_two_wr; wr && paddr_i == 8'hb8 |=> tap_two_coeff_o == $past(pwdata_i[7:0]); endproperty
    a_tap_two_wr: assert property (p_tap_two_wr)
        else $error("tap two coefficient not written");
    property p_tap_three_wr; wr && paddr_i == 8'hbc |=> tap_three_coeff_o == $past(pwdata_i[7:0]); endproperty
    a_tap_three_wr: assert property (p_tap_three_wr)
        else $error("tap three coefficient not written");
    property p_tap_four_wr; wr && paddr_i == 8'hc0 |=> tap_four_coeff_o == $past(pwdata_i[7:0]); endproperty
    a_tap_four_wr: assert property (p_tap_four_wr)
        else $error("tap four coefficient not written");
    property p_read_value; acc && !pwrite_i && paddr_i == 8'hb4 |-> prdata_o == {24'h0, tap_one_coeff_o}; endproperty
    a_read_value: assert property (p_read_value)
        else $error("tap one read data wrong");
    property p_coeff_hold;
        !wr |=> $stable({tap_one_coeff_o, tap_two_coeff_o, tap_three_coeff_o, tap_four_coeff_o});
    endproperty
    a_coeff_hold: assert property (p_coeff_hold)
        else $error("coefficient changed without a write");
    property p_reset_clear;
        $rose(reset_n_i) |-> {tap_one_coeff_o, tap_two_coeff_o, tap_three_coeff_o, tap_four_coeff_o} == 32'h0;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("coefficients not cleared by reset");
    property p_clean_lat; sample_valid_i |-> ##3 rx_clean_valid_o; endproperty
    a_clean_lat: assert property (p_clean_lat)
        else $error("cleaned sample not three cycles after input");

    c_write: cover property (wr);
    c_error: cover property (acc && pslverr_o);
    c_clean: cover property (rx_clean_valid_o);
endmodule // hetc_checker

bind hetc_top hetc_checker #(.ADDR_W(ADDR_W), .COEF_W(COEF_W)) hetc_checker_i (.clk_sys_i, .reset_n_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o,
    .sample_valid_i, .rx_clean_valid_o, .tap_one_coeff_o, .tap_two_coeff_o, .tap_three_coeff_o,
    .tap_four_coeff_o);
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench of hetc_top: coefficient registers over APB and echo removal.
// Assumes the checker binds itself; expected values queue up for a monitor process.
`timescale 1ns/1ns
`default_nettype none
`include "hetc_consts.vh"
module testbench;
    logic        clk_sys_i, reset_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [7:0]  paddr_i, tap_one_coeff_o, tap_two_coeff_o, tap_three_coeff_o, tap_four_coeff_o;
    logic [31:0] pwdata_i, prdata_o, tap_upper_coeff_i, r;
    logic [3:0]  pstrb_i;
    logic        sample_valid_i, rx_clean_valid_o;
    logic [15:0] tx_sample_i, rx_sample_i, rx_clean_o;
    logic [7:0]  coef [8];
    logic [15:0] txh [8];
    logic [31:0] seed = 32'h0000_000f;
    logic        echo_on = 1'b1, sat_seen = 1'b0;
    logic [32:0] q_bus [$];
    logic [15:0] q_rx [$];
    int          failures = 0, n_tests = 0, cyc = 0, n_smp = 0;

    hetc_top hetc_top_i (.clk_sys_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .sample_valid_i, .tx_sample_i, .rx_sample_i,
        .rx_clean_valid_o, .rx_clean_o, .tap_upper_coeff_i, .tap_one_coeff_o, .tap_two_coeff_o,
        .tap_three_coeff_o, .tap_four_coeff_o);

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] tap_addr(input int i);
        return {`HETC_IDX_TAP_ONE + 6'(i), 2'b00};
    endfunction

    task automatic chk(input string name, input logic [32:0] exp, input logic [32:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Leaves the bus requesting, so a following call makes a back-to-back transfer.
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
                       input logic [32:0] e);
        q_bus.push_back(e);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        paddr_i <= a;
        pwrite_i <= w;
        pwdata_i <= d;
        pstrb_i <= s;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        @(posedge clk_sys_i);
        while (pready_o !== 1'b1) @(posedge clk_sys_i);
    endtask

    task automatic idle();
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic read_taps();
        for (int i = 0; i < 4; i++) apb(tap_addr(i), 1'b0, rnd(), 4'hf, {25'h0, coef[i]});
        idle();
        chk("tap_one", {25'h0, coef[0]}, {25'h0, tap_one_coeff_o});
        chk("tap_two", {25'h0, coef[1]}, {25'h0, tap_two_coeff_o});
        chk("tap_three", {25'h0, coef[2]}, {25'h0, tap_three_coeff_o});
        chk("tap_four", {25'h0, coef[3]}, {25'h0, tap_four_coeff_o});
    endtask

    // Reference echo removal: newest transmit sample meets tap one.
    task automatic sample();
        logic [15:0]        t, x;
        logic signed [31:0] est;
        t = 16'(rnd());
        x = 16'(rnd());
        for (int k = 7; k > 0; k--) txh[k] = txh[k-1];
        txh[0] = t;
        est = 0;
        for (int k = 0; k < 8; k++) est += $signed(coef[k]) * $signed(txh[k]);
        if (!echo_on) est = 0;
        est = $signed({{16{x[15]}}, x}) - (est >>> 7);
        if (est > 32767 || est < -32768) sat_seen = 1'b1;
        if (est > 32767) est = 32767;
        else if (est < -32768) est = -32768;
        q_rx.push_back(est[15:0]);
        n_smp++;
        sample_valid_i <= 1'b1;
        tx_sample_i <= t;
        rx_sample_i <= x;
        @(posedge clk_sys_i);
        sample_valid_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
    endtask

    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (psel_i && penable_i && pready_o === 1'b1)
            chk("apb", q_bus.pop_front(), {pslverr_o, prdata_o});
        if (rx_clean_valid_o === 1'b1)
            chk("rx_clean", {17'h0, q_rx.pop_front()}, {17'h0, rx_clean_o});
        if (cyc == 5000) begin
            failures++;
            stop_test();
        end
    end

    initial begin
        {reset_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, pstrb_i} = '0;
        {sample_valid_i, tx_sample_i, rx_sample_i, tap_upper_coeff_i} = '0;
        for (int k = 0; k < 8; k++) {coef[k], txh[k]} = '0;
        repeat (12) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        read_taps();
        for (int n = 0; n < 12; n++) begin
            for (int i = 0; i < 8; i++) begin
                r = rnd();
                coef[i] = (n == 0 || r[9:8] == 2'b00) ? 8'h00 : r[7:0];
            end
            for (int i = 0; i < 4; i++) begin
                r = rnd();
                apb(tap_addr(i), 1'b1, {r[31:8], coef[i]}, 4'hf, 33'h0);
            end
            read_taps();
            tap_upper_coeff_i <= {coef[7], coef[6], coef[5], coef[4]};
            repeat (3) sample();
        end
        // Own registers: sample count, sticky saturation and the bypass of the estimate.
        apb(8'he8, 1'b0, rnd(), 4'hf, 33'(n_smp));
        apb(8'he4, 1'b0, rnd(), 4'hf, {32'h0, sat_seen});
        apb(8'he4, 1'b1, 32'h1, 4'hf, 33'h0);
        apb(8'he0, 1'b1, 32'h2, 4'hf, 33'h0);
        apb(8'he0, 1'b0, rnd(), 4'hf, 33'h0);
        idle();
        echo_on = 1'b0;
        sat_seen = 1'b0;
        n_smp = 0;
        sample();
        apb(8'he8, 1'b0, rnd(), 4'hf, 33'(n_smp));
        apb(8'he4, 1'b0, rnd(), 4'hf, {32'h0, sat_seen});
        apb(8'hec, 1'b0, rnd(), 4'hf, 33'h0);
        apb(8'he0, 1'b1, 32'h1, 4'hf, 33'h0);
        echo_on = 1'b1;
        // Refused accesses: a write with lane zero off, an unaligned write and a read of an unmapped place.
        apb(tap_addr(1), 1'b1, ~{24'h0, coef[1]}, 4'he, 33'h0);
        apb(tap_addr(0) | 8'h01, 1'b1, ~{24'h0, coef[0]}, 4'hf, {1'b1, 32'h0});
        apb(8'h00, 1'b0, 32'h0, 4'hf, {1'b1, 32'h0});
        read_taps();
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        for (int k = 0; k < 8; k++) coef[k] = 8'h00;
        read_taps();
        apb(8'he0, 1'b0, rnd(), 4'hf, 33'h1);
        idle();
        chk("rx_pending", 33'h0, 33'(q_rx.size()));
        chk("apb_pending", 33'h0, 33'(q_bus.size()));
        stop_test();
    end
endmodule // testbench
`default_nettype wire

// *** logic/hetc_consts.vh ***
// Constants for the lower hybrid echo tap coefficient block.
// Assumes inclusion by bare name from the design files of this block.
`ifndef HETC_CONSTS_VH
`define HETC_CONSTS_VH

// Register indices; the byte address is four times the index.
`define HETC_IDX_TAP_ONE    6'h2d
`define HETC_IDX_TAP_TWO    6'h2e
`define HETC_IDX_TAP_THREE  6'h2f
`define HETC_IDX_TAP_FOUR   6'h30
`define HETC_IDX_CTRL       6'h38
`define HETC_IDX_STATUS     6'h39
`define HETC_IDX_SAMPLES    6'h3a
`define HETC_IDX_ESTIMATE   6'h3b

// Field positions.
`define HETC_COEFF_MSB      7
`define HETC_CTRL_ENABLE    0
`define HETC_CTRL_CLR_CNT   1
`define HETC_STAT_SAT       0
`define HETC_STAT_BUSY      1

// Reset values.
`define HETC_COEFF_RESET    8'h00
`define HETC_CTRL_RESET     1'h1
`define HETC_DATA_RESET     32'h0000_0000

// Filter shape.
`define HETC_NUM_TAPS       8
`define HETC_LOWER_TAPS     4
`define HETC_PIPE_CYCLES    2

`endif

// *** logic/hetc_delay_line.v ***
// Delay line of transmit samples feeding the echo taps.
// Assumes a shift strobe from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

module hetc_delay_line #(
    parameter DATA_W = 16,
    parameter DEPTH  = 8
) (
    // Clock and reset.
    input  wire                      clk_sys_i,
    input  wire                      reset_n_i,
    // Sample input.
    input  wire                      shift_i,
    input  wire [DATA_W-1:0]         sample_i,
    // All stages, newest in the low slice.
    output wire [DEPTH*DATA_W-1:0]   taps_o
);

    reg  [DATA_W-1:0] stage_q [0:DEPTH-1];

    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : g_stage
            always @(posedge clk_sys_i) begin
                if (!reset_n_i) begin
                    stage_q[g] <= {DATA_W{1'b0}};
                end else if (shift_i) begin
                    if (g == 0) begin
                        stage_q[g] <= sample_i;
                    end else begin
                        stage_q[g] <= stage_q[(g > 0) ? g - 1 : 0];
                    end
                end
            end
            assign taps_o[g*DATA_W +: DATA_W] = stage_q[g];
        end
    endgenerate

endmodule // hetc_delay_line

`default_nettype wire

// *** logic/hetc_tap_mul.v ***
// One coefficient-weighted tap of the echo estimate.
// Assumes signed two's complement sample and coefficient.
`timescale 1ns/1ns
`default_nettype none

module hetc_tap_mul #(
    parameter DATA_W = 16,
    parameter COEF_W = 8
) (
    // Operands.
    input  wire [DATA_W-1:0]         sample_i,
    input  wire [COEF_W-1:0]         coeff_i,
    // Product.
    output wire [DATA_W+COEF_W-1:0]  prod_o
);

    wire signed [DATA_W+COEF_W-1:0] product;

    assign product = $signed(sample_i) * $signed(coeff_i);

    // A zero coefficient forces the product off so the tap adds nothing.
    assign prod_o = (coeff_i == {COEF_W{1'b0}}) ? {(DATA_W+COEF_W){1'b0}} : product;

endmodule // hetc_tap_mul

`default_nettype wire

// *** logic/hetc_top.v ***
// Lower hybrid echo tap coefficients with the eight-tap echo canceller.
// Assumes an APB master on clk_sys_i and sample strobes from the same clock.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "hetc_consts.vh"

// Operation
// - The tap one coefficient register bits 7:0 weight the first filter tap.
// - The tap two coefficient register bits 7:0 weight the second filter tap.
// - The tap three coefficient register bits 7:0 weight the third filter tap.
// - The tap four coefficient register bits 7:0 weight the fourth filter tap.
// - A coefficient of all zeros makes its tap add nothing to the hybrid response.
// - Software can read and write every coefficient register.
// - Reset clears the coefficient registers to zero so the taps start with no effect.
module hetc_top #(
    parameter ADDR_W    = 8,
    parameter DATA_W    = 16,
    parameter COEF_W    = 8,
    parameter COEF_FRAC = 7
) (
    // Clock and reset.
    input  wire                      clk_sys_i,
    input  wire                      reset_n_i,
    // APB slave.
    input  wire                      psel_i,
    input  wire                      penable_i,
    input  wire                      pwrite_i,
    input  wire [ADDR_W-1:0]         paddr_i,
    input  wire [31:0]               pwdata_i,
    input  wire [3:0]                pstrb_i,
    output reg  [31:0]               prdata_o,
    output reg                       pready_o,
    output reg                       pslverr_o,
    // Sample path.
    input  wire                      sample_valid_i,
    input  wire [DATA_W-1:0]         tx_sample_i,
    input  wire [DATA_W-1:0]         rx_sample_i,
    output reg                       rx_clean_valid_o,
    output reg  [DATA_W-1:0]         rx_clean_o,
    // Upper four coefficients, tap five in the low byte.
    input  wire [4*COEF_W-1:0]       tap_upper_coeff_i,
    // Lower four coefficients.
    output reg  [COEF_W-1:0]         tap_one_coeff_o,
    output reg  [COEF_W-1:0]         tap_two_coeff_o,
    output reg  [COEF_W-1:0]         tap_three_coeff_o,
    output reg  [COEF_W-1:0]         tap_four_coeff_o
);

    localparam NTAP  = `HETC_NUM_TAPS;
    localparam PW    = DATA_W + COEF_W;
    localparam ACC_W = PW + 4;

    localparam [ACC_W-1:0] SAT_MAX = {{(ACC_W-DATA_W+1){1'b0}}, {(DATA_W-1){1'b1}}};
    localparam [ACC_W-1:0] SAT_MIN = {{(ACC_W-DATA_W+1){1'b1}}, {(DATA_W-1){1'b0}}};

    // APB decode.
    wire                 setup_phase;
    wire                 write_commit;
    wire [ADDR_W-3:0]    reg_idx;
    wire                 aligned;
    wire                 lane0;

    // Control and status.
    reg                  hybrid_enable;
    reg                  sat_sticky;
    reg  [31:0]          sample_count;
    reg  [ACC_W-1:0]     estimate_q;
    reg  [31:0]          next_rdata;
    reg                  next_err;

    // Datapath.
    wire [NTAP*DATA_W-1:0] taps;
    wire [NTAP*COEF_W-1:0] coeff_all;
    wire [NTAP*PW-1:0]     prod_all;
    reg  [PW-1:0]          prod_q [0:NTAP-1];
    reg  [DATA_W-1:0]      rx_q;
    reg                    stage1_valid;
    reg  [ACC_W-1:0]       next_sum;
    reg  [ACC_W-1:0]       next_est;
    reg  [ACC_W-1:0]       next_diff;
    reg  [DATA_W-1:0]      next_clean;
    reg                    next_sat;
    integer                i;

    assign setup_phase  = psel_i && !penable_i;
    assign write_commit = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
    assign reg_idx      = paddr_i[ADDR_W-1:2];
    assign aligned      = (paddr_i[1:0] == 2'h0);
    assign lane0        = pstrb_i[0];

    // Read mux and error decode, sampled in the setup phase.
    always @* begin
        next_rdata = `HETC_DATA_RESET;
        next_err   = 1'b0;
        case (reg_idx)
            `HETC_IDX_TAP_ONE: begin
                next_rdata[COEF_W-1:0] = tap_one_coeff_o;
            end
            `HETC_IDX_TAP_TWO: begin
                next_rdata[COEF_W-1:0] = tap_two_coeff_o;
            end
            `HETC_IDX_TAP_THREE: begin
                next_rdata[COEF_W-1:0] = tap_three_coeff_o;
            end
            `HETC_IDX_TAP_FOUR: begin
                next_rdata[COEF_W-1:0] = tap_four_coeff_o;
            end
            `HETC_IDX_CTRL: begin
                next_rdata[`HETC_CTRL_ENABLE] = hybrid_enable;
            end
            `HETC_IDX_STATUS: begin
                next_rdata[`HETC_STAT_SAT]  = sat_sticky;
                next_rdata[`HETC_STAT_BUSY] = stage1_valid | rx_clean_valid_o;
            end
            `HETC_IDX_SAMPLES: begin
                next_rdata = sample_count;
            end
            `HETC_IDX_ESTIMATE: begin
                next_rdata = {{(32-ACC_W){estimate_q[ACC_W-1]}}, estimate_q};
            end
            default: begin
                next_err = 1'b1;
            end
        endcase
        if (!aligned) begin
            next_err   = 1'b1;
            next_rdata = `HETC_DATA_RESET;
        end
        if (pwrite_i && !next_err) begin
            next_rdata = `HETC_DATA_RESET;
        end
    end

    // Zero-wait slave: the answer is registered in setup and shown in access.
    always @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= `HETC_DATA_RESET;
        end else if (setup_phase) begin
            pready_o  <= 1'b1;
            pslverr_o <= next_err;
            prdata_o  <= next_rdata;
        end else begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

    // Coefficient registers; a write lands only on the edge that ends the access.
    always @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            tap_one_coeff_o   <= `HETC_COEFF_RESET;
            tap_two_coeff_o   <= `HETC_COEFF_RESET;
            tap_three_coeff_o <= `HETC_COEFF_RESET;
            tap_four_coeff_o  <= `HETC_COEFF_RESET;
        end else if (write_commit && lane0) begin
            case (reg_idx)
                `HETC_IDX_TAP_ONE: begin
                    tap_one_coeff_o <= pwdata_i[COEF_W-1:0];
                end
                `HETC_IDX_TAP_TWO: begin
                    tap_two_coeff_o <= pwdata_i[COEF_W-1:0];
                end
                `HETC_IDX_TAP_THREE: begin
                    tap_three_coeff_o <= pwdata_i[COEF_W-1:0];
                end
                `HETC_IDX_TAP_FOUR: begin
                    tap_four_coeff_o <= pwdata_i[COEF_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Control register and sample counter.
    always @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            hybrid_enable <= `HETC_CTRL_RESET;
            sample_count  <= `HETC_DATA_RESET;
        end else begin
            if (write_commit && lane0 && reg_idx == `HETC_IDX_CTRL) begin
                hybrid_enable <= pwdata_i[`HETC_CTRL_ENABLE];
            end
            if (write_commit && lane0 && reg_idx == `HETC_IDX_CTRL && pwdata_i[`HETC_CTRL_CLR_CNT]) begin
                sample_count <= `HETC_DATA_RESET;
            end else if (sample_valid_i) begin
                sample_count <= sample_count + 32'h0000_0001;
            end
        end
    end

    // Saturation flag clears on a write of one; a new event in that cycle wins.
    always @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            sat_sticky <= 1'b0;
        end else if (rx_clean_valid_o == 1'b0 && stage1_valid && next_sat) begin
            sat_sticky <= 1'b1;
        end else if (stage1_valid && next_sat) begin
            sat_sticky <= 1'b1;
        end else if (write_commit && lane0 && reg_idx == `HETC_IDX_STATUS && pwdata_i[`HETC_STAT_SAT]) begin
            sat_sticky <= 1'b0;
        end
    end

    // Transmit history, newest sample first.
    hetc_delay_line #(
        .DATA_W (DATA_W),
        .DEPTH  (NTAP)
    ) u_delay (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .shift_i   (sample_valid_i),
        .sample_i  (tx_sample_i),
        .taps_o    (taps)
    );

    // Tap order: one to four from the registers, five to eight from outside.
    assign coeff_all = {tap_upper_coeff_i,
                        tap_four_coeff_o,
                        tap_three_coeff_o,
                        tap_two_coeff_o,
                        tap_one_coeff_o};

    genvar g;
    generate
        for (g = 0; g < NTAP; g = g + 1) begin : g_tap
            hetc_tap_mul #(
                .DATA_W (DATA_W),
                .COEF_W (COEF_W)
            ) u_mul (
                .sample_i (taps[g*DATA_W +: DATA_W]),
                .coeff_i  (coeff_all[g*COEF_W +: COEF_W]),
                .prod_o   (prod_all[g*PW +: PW])
            );

            // Products are captured one cycle after the delay line shifts.
            always @(posedge clk_sys_i) begin
                if (!reset_n_i) begin
                    prod_q[g] <= {PW{1'b0}};
                end else begin
                    prod_q[g] <= prod_all[g*PW +: PW];
                end
            end
        end
    endgenerate

    // Stage one marks the cycle in which the fresh products are in prod_q.
    reg shift_d;

    always @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            shift_d      <= 1'b0;
            stage1_valid <= 1'b0;
            rx_q         <= {DATA_W{1'b0}};
        end else begin
            shift_d      <= sample_valid_i;
            stage1_valid <= shift_d;
            if (sample_valid_i) begin
                rx_q <= rx_sample_i;
            end
        end
    end

    // Echo estimate and its removal, saturated to the sample range.
    always @* begin
        next_sum = {ACC_W{1'b0}};
        for (i = 0; i < NTAP; i = i + 1) begin
            next_sum = next_sum + {{(ACC_W-PW){prod_q[i][PW-1]}}, prod_q[i]};
        end
        next_est = $signed(next_sum) >>> COEF_FRAC;
        if (!hybrid_enable) begin
            next_est = {ACC_W{1'b0}};
        end
        next_diff  = {{(ACC_W-DATA_W){rx_q[DATA_W-1]}}, rx_q} - next_est;
        next_sat   = 1'b0;
        next_clean = next_diff[DATA_W-1:0];
        if ($signed(next_diff) > $signed(SAT_MAX)) begin
            next_clean = SAT_MAX[DATA_W-1:0];
            next_sat   = 1'b1;
        end else if ($signed(next_diff) < $signed(SAT_MIN)) begin
            next_clean = SAT_MIN[DATA_W-1:0];
            next_sat   = 1'b1;
        end
    end

    // Registered cleaned receive sample.
    always @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            rx_clean_valid_o <= 1'b0;
            rx_clean_o       <= {DATA_W{1'b0}};
            estimate_q       <= {ACC_W{1'b0}};
        end else begin
            rx_clean_valid_o <= stage1_valid;
            if (stage1_valid) begin
                rx_clean_o <= next_clean;
                estimate_q <= next_est;
            end
        end
    end

endmodule // hetc_top

`default_nettype wire
